// ### rtl/bus_cmd_params.svh
/*
 * Shared constants of the general bus command handler: command byte codes,
 * address group layout and default configuration values.
 * Assumes the includer wants plain `define names; guarded against double inclusion.
 */
`ifndef BUS_CMD_PARAMS_SVH
`define BUS_CMD_PARAMS_SVH

// universal and addressed command bytes, parity bit stripped
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3F
`define CMD_UNT 7'h5F
// address groups: bits 6:5 select listen/talk, bits 4:0 carry the address
`define GRP_HI 6
`define GRP_LO 5
`define ADDR_HI 4
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
// default configuration
`define DEF_FUNC 3'h0
`define DEF_RANGE 3'h4
`define DEF_PREFIX 1'h1
`define DEF_SRQ_EN 1'h0
`define DEF_ZERO 2'h0
`define DEF_FILTER 7'h00
`define DEF_DELAY 1'h0
`define DEF_EOI_EN 1'h1
`define DEF_HOLDOFF 1'h1
`define DEF_TERM 2'h0
`define DEF_TRIG 3'h6
`define DEF_STORE 1'h0
`define DEF_BUF_SIZE 10'h001
`define DEF_LINE_FREQ 1'h0
`define DEF_BUS_ADDR 5'h07
// trigger modes that accept a bus trigger
`define TRIG_GET_A 3'h2
`define TRIG_GET_B 3'h3
// serial poll byte: bit 6 marks this device as requesting service
`define SPB_RQS 6

`endif

// ### rtl/bus_cmd_pkg.sv
/*
 * Types of the general bus command handler.
 * Assumes nothing beyond the standard language.
 */
package bus_cmd_pkg;
	typedef enum logic [1:0] {
		POLL_OFF = 2'b00,
		POLL_ARMED = 2'b01,
		POLL_SEND = 2'b10,
		POLL_DONE = 2'b11
	} poll_state_e;
endpackage : bus_cmd_pkg

// ### rtl/gpib_bus_command_handler.sv
/*
 * General bus command handler: remote/local, lockout, device clear,
 * selective clear, group trigger and serial poll with status byte return.
 * Assumes the byte handshake is done elsewhere: bus lines arrive raw from pins
 * and a received byte is flagged by byte_strobe_n (active low, one per byte).
 */
// Functional notes
// R1: go-to-local while listener returns to local
// R2: controller sends ATN, listen address, GTL
// R3: go-to-local leaves lockout in force
// R4: device clear acts without addressing
// R5: device clear restores factory or user defaults
// R6: controller sends ATN then DCL byte
// R7: device clear restores line frequency, keeps address
// R8: selective clear acts only when listener
// R9: controller sends ATN, listen address, SDC
// R10: selective clear restores frequency, keeps address
// R11: group trigger starts measurement in bus modes
// R12: triggered run uses stored rate and samples
// R13: controller sends ATN, listen address, GET
// R14: poll enable arms all devices for polling
// R15: armed and talker with ATN off: drive byte
// R16: controller ends polling with poll disable
// R17: each polled talker returns own byte
// R18: status byte shows own service request
// R19: default DCV 300V, prefix, features off
// R20: default EOI, hold-off, CR LF terminator
// R21: default continuous external trigger, one-shot store
// R22: remote only when REN and then listener
// R23: lockout disables front-panel local key
// R24: interface clear idles talker and listener
// R25: addressed only by own primary address
`include "bus_cmd_params.svh"

module gpib_bus_command_handler import bus_cmd_pkg::*; #(
	parameter logic [4:0] BUS_ADDR_DEFAULT = `DEF_BUS_ADDR
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic atn_n,
	input wire logic ren_n,
	input wire logic ifc_n,
	input wire logic [7:0] dio_n_in,
	input wire logic byte_strobe_n,
	output logic [7:0] dio_n_out,
	output logic [7:0] dio_n_oe,
	input wire logic [4:0] bus_addr_in,
	input wire logic bus_addr_load,
	input wire logic local_key,
	input wire logic use_user_defaults,
	input wire logic [2:0] user_func,
	input wire logic [2:0] user_range,
	input wire logic [2:0] user_trig,
	input wire logic [2:0] rate_sel,
	input wire logic [9:0] sample_count,
	input wire logic [6:0] status_bits,
	input wire logic srq_pending,
	output logic remote,
	output logic lockout,
	output logic talker,
	output logic listener,
	output logic poll_enabled,
	output logic panel_enable,
	output logic meas_start,
	output logic [2:0] meas_rate,
	output logic [9:0] meas_samples,
	output logic clear_pulse,
	output logic [2:0] cfg_func,
	output logic [2:0] cfg_range,
	output logic cfg_prefix,
	output logic cfg_srq_en,
	output logic [1:0] cfg_zero,
	output logic [6:0] cfg_filter,
	output logic cfg_delay,
	output logic cfg_eoi_en,
	output logic cfg_holdoff,
	output logic [1:0] cfg_term,
	output logic [2:0] cfg_trig,
	output logic cfg_store_cont,
	output logic [9:0] cfg_buf_size,
	output logic cfg_line_freq,
	output logic [4:0] bus_addr
);
	// pin synchronisers: first stage read only by the second
	logic [11:0] sync1_reg;
	logic [11:0] sync2_reg;
	logic strobe_d_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 12'hFFF;
			sync2_reg <= 12'hFFF;
			strobe_d_reg <= 1'b1;
		end else begin
			sync1_reg <= {atn_n, ren_n, ifc_n, byte_strobe_n, dio_n_in};
			sync2_reg <= sync1_reg;
			strobe_d_reg <= sync2_reg[8];
		end
	end
	logic atn, ren, ifc;
	logic [6:0] rx;
	logic rx_take;
	assign atn = ~sync2_reg[11];
	assign ren = ~sync2_reg[10];
	assign ifc = ~sync2_reg[9];
	assign rx = ~sync2_reg[6:0];
	// falling edge of the strobe: data was stable across both stages
	assign rx_take = strobe_d_reg & ~sync2_reg[8];

	function automatic logic is_cmd(input logic [6:0] b, input logic [6:0] code);
		is_cmd = (b == code);
	endfunction : is_cmd

	logic cmd;
	logic my_listen;
	logic my_talk;
	assign cmd = rx_take & atn;
	assign my_listen = cmd && rx[`GRP_HI:`GRP_LO] == `GRP_LISTEN
		&& rx[`ADDR_HI:0] == bus_addr; // R25
	assign my_talk = cmd && rx[`GRP_HI:`GRP_LO] == `GRP_TALK
		&& rx[`ADDR_HI:0] == bus_addr; // R25

	logic remote_reg, remote_next;
	logic lockout_reg, lockout_next;
	logic talker_reg, talker_next;
	logic listener_reg, listener_next;
	logic [4:0] addr_reg, addr_next;
	poll_state_e poll_reg, poll_next;
	logic do_clear, do_trig;

	always_comb begin
		remote_next = remote_reg;
		lockout_next = lockout_reg;
		talker_next = talker_reg;
		listener_next = listener_reg;
		addr_next = addr_reg;
		poll_next = poll_reg;
		do_clear = 1'b0;
		do_trig = 1'b0;
		// address only set by its own port or by reset, never by a clear
		if (bus_addr_load) begin
			addr_next = bus_addr_in; // R7 R10
		end
		if (my_listen) begin
			listener_next = 1'b1;
			talker_next = 1'b0;
			if (ren) begin
				remote_next = 1'b1; // R22
			end
		end
		if (my_talk) begin
			talker_next = 1'b1;
			listener_next = 1'b0;
		end
		if (cmd && is_cmd(rx, `CMD_UNL)) begin
			listener_next = 1'b0;
		end
		if (cmd && rx[`GRP_HI:`GRP_LO] == `GRP_TALK
			&& (is_cmd(rx, `CMD_UNT) || rx[`ADDR_HI:0] != bus_addr)) begin
			talker_next = 1'b0; // R17
		end
		if (cmd && is_cmd(rx, `CMD_GTL) && listener_reg) begin
			remote_next = 1'b0; // R1 R3
		end
		if (cmd && is_cmd(rx, `CMD_LLO)) begin
			lockout_next = 1'b1;
		end
		if (cmd && is_cmd(rx, `CMD_DCL)) begin
			do_clear = 1'b1; // R4
		end
		if (cmd && is_cmd(rx, `CMD_SDC) && listener_reg) begin
			do_clear = 1'b1; // R8
		end
		if (cmd && is_cmd(rx, `CMD_GET) && listener_reg
			&& (cfg_trig == `TRIG_GET_A || cfg_trig == `TRIG_GET_B)) begin
			do_trig = 1'b1; // R11
		end
		case (poll_reg)
			POLL_OFF: begin
				if (cmd && is_cmd(rx, `CMD_SPE)) begin
					poll_next = POLL_ARMED; // R14
				end
			end
			POLL_ARMED, POLL_SEND, POLL_DONE: begin
				if (cmd && is_cmd(rx, `CMD_SPD)) begin
					poll_next = POLL_OFF;
				end else if (atn) begin
					poll_next = POLL_ARMED; // R15
				end else if (rx_take && poll_reg == POLL_SEND) begin
					// byte taken: keep off the lines until ATN comes back
					poll_next = POLL_DONE; // R17
				end else if (talker_next && poll_reg == POLL_ARMED) begin
					poll_next = POLL_SEND; // R15
				end
			end
			default: poll_next = POLL_OFF;
		endcase
		if (local_key && !lockout_reg) begin
			remote_next = 1'b0; // R23
		end
		// releasing REN and reset are the only paths out of lockout
		if (!ren) begin
			remote_next = 1'b0;
			lockout_next = 1'b0; // R3
		end
		if (ifc) begin
			talker_next = 1'b0; // R24
			listener_next = 1'b0; // R24
			poll_next = POLL_OFF;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			remote_reg <= 1'b0;
			lockout_reg <= 1'b0;
			talker_reg <= 1'b0;
			listener_reg <= 1'b0;
			addr_reg <= BUS_ADDR_DEFAULT;
			poll_reg <= POLL_OFF;
		end else begin
			remote_reg <= remote_next;
			lockout_reg <= lockout_next;
			talker_reg <= talker_next;
			listener_reg <= listener_next;
			addr_reg <= addr_next;
			poll_reg <= poll_next;
		end
	end

	// configuration group
	logic [2:0] func_reg, func_next, range_reg, range_next, trig_reg, trig_next;
	logic [1:0] zero_reg, zero_next, term_reg, term_next;
	logic [6:0] filter_reg, filter_next;
	logic [9:0] bufsz_reg, bufsz_next;
	logic [7:0] flags_reg, flags_next;
	logic [2:0] rate_reg, rate_next;
	logic [9:0] samp_reg, samp_next;
	logic start_reg, start_next;
	logic clr_reg, clr_next;
	logic [7:0] spb_reg, spb_next;
	localparam logic [7:0] FLAGS_DEF = {`DEF_PREFIX, `DEF_SRQ_EN, `DEF_DELAY, `DEF_EOI_EN,
		`DEF_HOLDOFF, `DEF_STORE, `DEF_LINE_FREQ, 1'b0};

	always_comb begin
		func_next = func_reg;
		range_next = range_reg;
		trig_next = trig_reg;
		zero_next = zero_reg;
		term_next = term_reg;
		filter_next = filter_reg;
		bufsz_next = bufsz_reg;
		flags_next = flags_reg;
		rate_next = rate_reg;
		samp_next = samp_reg;
		start_next = do_trig;
		clr_next = do_clear;
		spb_next = spb_reg;
		if (do_clear) begin
			func_next = use_user_defaults ? user_func : `DEF_FUNC; // R5 R19
			range_next = use_user_defaults ? user_range : `DEF_RANGE; // R5 R19
			trig_next = use_user_defaults ? user_trig : `DEF_TRIG; // R5 R21
			zero_next = `DEF_ZERO; // R19
			filter_next = `DEF_FILTER; // R19
			term_next = `DEF_TERM; // R20
			bufsz_next = `DEF_BUF_SIZE; // R21
			flags_next = FLAGS_DEF; // R7 R10 R19 R20 R21
		end
		if (do_trig) begin
			rate_next = rate_sel; // R12
			samp_next = sample_count; // R12
		end
		// snapshot when entering send so the byte holds still on the lines
		if (poll_next == POLL_SEND && poll_reg != POLL_SEND) begin
			spb_next = {1'b0, status_bits}; // R17
			spb_next[`SPB_RQS] = srq_pending & flags_reg[6]; // R18
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			func_reg <= `DEF_FUNC;
			range_reg <= `DEF_RANGE;
			trig_reg <= `DEF_TRIG;
			zero_reg <= `DEF_ZERO;
			term_reg <= `DEF_TERM;
			filter_reg <= `DEF_FILTER;
			bufsz_reg <= `DEF_BUF_SIZE;
			flags_reg <= FLAGS_DEF;
			rate_reg <= 3'h0;
			samp_reg <= 10'h000;
			start_reg <= 1'b0;
			clr_reg <= 1'b0;
			spb_reg <= 8'h00;
		end else begin
			func_reg <= func_next;
			range_reg <= range_next;
			trig_reg <= trig_next;
			zero_reg <= zero_next;
			term_reg <= term_next;
			filter_reg <= filter_next;
			bufsz_reg <= bufsz_next;
			flags_reg <= flags_next;
			rate_reg <= rate_next;
			samp_reg <= samp_next;
			start_reg <= start_next;
			clr_reg <= clr_next;
			spb_reg <= spb_next;
		end
	end

	// lines are active low: driving a one bit pulls the line
	assign dio_n_out = ~spb_reg;
	assign dio_n_oe = {8{poll_reg == POLL_SEND}}; // R15
	assign remote = remote_reg;
	assign lockout = lockout_reg;
	assign talker = talker_reg;
	assign listener = listener_reg;
	assign poll_enabled = poll_reg != POLL_OFF;
	assign panel_enable = ~remote_reg; // R1
	assign meas_start = start_reg;
	assign meas_rate = rate_reg;
	assign meas_samples = samp_reg;
	assign clear_pulse = clr_reg;
	assign cfg_func = func_reg;
	assign cfg_range = range_reg;
	assign cfg_prefix = flags_reg[7];
	assign cfg_srq_en = flags_reg[6];
	assign cfg_delay = flags_reg[5];
	assign cfg_eoi_en = flags_reg[4];
	assign cfg_holdoff = flags_reg[3];
	assign cfg_store_cont = flags_reg[2];
	assign cfg_line_freq = flags_reg[1];
	assign cfg_zero = zero_reg;
	assign cfg_filter = filter_reg;
	assign cfg_term = term_reg;
	assign cfg_trig = trig_reg;
	assign cfg_buf_size = bufsz_reg;
	assign bus_addr = addr_reg;
endmodule : gpib_bus_command_handler

// ### tb/bus_cmd_checker.sv
/* assertions on the ports of the bus command handler
   bound onto every gpib_bus_command_handler instance */
`include "bus_cmd_params.svh"
module bus_cmd_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic ren_n,
	input wire logic ifc_n,
	input wire logic bus_addr_load,
	input wire logic [7:0] dio_n_out,
	input wire logic [7:0] dio_n_oe,
	input wire logic remote,
	input wire logic lockout,
	input wire logic talker,
	input wire logic listener,
	input wire logic poll_enabled,
	input wire logic panel_enable,
	input wire logic meas_start,
	input wire logic clear_pulse,
	input wire logic cfg_prefix,
	input wire logic cfg_srq_en,
	input wire logic cfg_eoi_en,
	input wire logic [2:0] cfg_trig,
	input wire logic cfg_line_freq,
	input wire logic [4:0] bus_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	panel_follow_a: assert property (panel_enable == !remote) else $error("panel enable");
	// the ren line passes a synchroniser, so its cause lies a few edges back
	lock_release_a: assert property ($fell(lockout) |-> $past(ren_n, 2) || $past(ren_n, 3)
		|| $past(ren_n, 4) || $past(ren_n, 5)) else $error("lockout dropped");
	remote_gate_a: assert property ($rose(remote) |-> listener && !$past(ren_n, 3))
		else $error("remote without ren");
	poll_drive_a: assert property (dio_n_oe != 8'h00 |-> dio_n_oe == 8'hFF && talker
		&& poll_enabled) else $error("bad drive");
	srq_bit_a: assert property (dio_n_oe[6] && !cfg_srq_en |-> dio_n_out[6])
		else $error("srq bit");
	trig_mode_a: assert property (meas_start |-> cfg_trig == `TRIG_GET_A
		|| cfg_trig == `TRIG_GET_B) else $error("bad trigger");
	start_pulse_a: assert property (meas_start |=> !meas_start) else $error("start pulse");
	ifc_idle_a: assert property (!ifc_n [*5] |-> !talker && !listener && !poll_enabled)
		else $error("ifc not idle");
	clear_dflt_a: assert property (clear_pulse |-> cfg_prefix && cfg_eoi_en && !cfg_srq_en
		&& cfg_line_freq == `DEF_LINE_FREQ) else $error("clear values");
	addr_keep_a: assert property (!$stable(bus_addr) |-> $past(bus_addr_load))
		else $error("address moved");
endmodule : bus_cmd_checker
bind gpib_bus_command_handler bus_cmd_checker u_bus_cmd_checker (.*);

// ### tb/bus_ctrl_model.sv
/* bus controller model: control lines and command bytes
   assumes lines are pulled up, so released lines read high */
module bus_ctrl_model (
	input wire logic clk,
	output logic atn_n,
	output logic ren_n,
	output logic ifc_n,
	output logic [7:0] dio_n,
	output logic strobe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		atn_n = 1'b1;
		ren_n = 1'b1;
		ifc_n = 1'b1;
		dio_n = 8'hFF;
		strobe_n = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_clk
	// atn and the byte set together, held well around the strobe
	task automatic send(input logic [6:0] b, input logic atn);
		atn_n = !atn;
		dio_n = atn ? ~{1'b0, b} : 8'hFF;
		wait_clk(4);
		strobe_n = 1'b0;
		wait_clk(5);
		strobe_n = 1'b1;
		wait_clk(1);
		dio_n = 8'hFF;
		wait_clk(4);
	endtask : send
	task automatic lines(input logic ren, input logic ifc, input logic atn);
		ren_n = !ren;
		ifc_n = !ifc;
		atn_n = !atn;
		wait_clk(7);
	endtask : lines
endmodule : bus_ctrl_model

// ### tb/tb.sv
/* self-checking bench for the bus command handler
   assumes the controller model and the bound checker */
`include "bus_cmd_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, atn_n, ren_n, ifc_n, byte_strobe_n, bus_addr_load, local_key;
	logic use_user_defaults, srq_pending, cfg_prefix, cfg_srq_en, cfg_delay, cfg_eoi_en;
	logic remote, lockout, talker, listener, poll_enabled, panel_enable, meas_start;
	logic clear_pulse, cfg_holdoff, cfg_store_cont, cfg_line_freq;
	logic [2:0] user_func, user_range, user_trig, rate_sel, meas_rate, cfg_func, cfg_range;
	logic [2:0] cfg_trig;
	logic [1:0] cfg_zero, cfg_term;
	logic [4:0] bus_addr_in, bus_addr;
	logic [6:0] status_bits, cfg_filter;
	logic [7:0] ctrl_dio, dio_n_out, dio_n_oe;
	logic [9:0] sample_count, meas_samples, cfg_buf_size;
	wire logic [7:0] dio_n_in;
	int n_errors, num_checks, n_start, n_clear;
	// open-collector bus: any driver pulling low wins
	assign dio_n_in = ctrl_dio & (dio_n_out | ~dio_n_oe);
	gpib_bus_command_handler u_gpib_bus_command_handler (.*);
	bus_ctrl_model u_bus_ctrl_model (.clk, .atn_n, .ren_n, .ifc_n, .dio_n(ctrl_dio),
		.strobe_n(byte_strobe_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (meas_start === 1'b1) n_start++;
		if (clear_pulse === 1'b1) n_clear++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [6:0] b);
		u_bus_ctrl_model.send(b, 1'b1);
	endtask : cmd
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#20000;
		n_errors++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		{bus_addr_load, local_key, use_user_defaults, srq_pending} = 4'h0;
		{user_func, user_range, user_trig, rate_sel} = 12'h000;
		{bus_addr_in, status_bits, sample_count} = 22'h0;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		u_bus_ctrl_model.wait_clk(4);
		chk({cfg_func, cfg_range, bus_addr}, {`DEF_FUNC, `DEF_RANGE, `DEF_BUS_ADDR});
		chk({cfg_prefix, cfg_srq_en, cfg_zero, cfg_filter, cfg_delay}, 12'h800);
		chk({cfg_eoi_en, cfg_holdoff, cfg_term}, {`DEF_EOI_EN, `DEF_HOLDOFF, `DEF_TERM});
		chk({cfg_trig, cfg_store_cont, cfg_buf_size}, {`DEF_TRIG, `DEF_STORE, 10'h001});
		$display("defaults done");
		cmd(7'h27);
		chk(remote, 0);
		u_bus_ctrl_model.lines(1, 0, 1);
		cmd(7'h27);
		chk({remote, panel_enable, listener}, 3'b101);
		cmd(`CMD_GTL);
		chk({remote, panel_enable}, 2'b01);
		cmd(`CMD_LLO);
		cmd(7'h27);
		cmd(`CMD_GTL);
		chk({lockout, remote}, 2'b10);
		cmd(7'h27);
		local_key = 1'b1;
		u_bus_ctrl_model.wait_clk(4);
		local_key = 1'b0;
		chk(remote, 1);
		u_bus_ctrl_model.lines(0, 0, 1);
		chk({lockout, remote}, 0);
		$display("remote done");
		cmd(`CMD_GET);
		chk(n_start, 0);
		{use_user_defaults, user_trig, user_func} = 7'h5D;
		cmd(`CMD_UNL);
		cmd(`CMD_SDC);
		chk({n_clear, cfg_trig}, {8'h0, `DEF_TRIG});
		cmd(`CMD_DCL);
		chk({n_clear, cfg_trig, cfg_func}, {8'h1, 3'h3, 3'h5});
		rate_sel = 3'h5;
		sample_count = 10'h123;
		cmd(7'h27);
		cmd(`CMD_GET);
		chk({n_start, meas_rate, meas_samples}, {3'h1, 3'h5, 10'h123});
		use_user_defaults = 1'b0;
		bus_addr_in = 5'h05;
		bus_addr_load = 1'b1;
		u_bus_ctrl_model.wait_clk(1);
		bus_addr_load = 1'b0;
		cmd(`CMD_SDC);
		chk({n_clear, cfg_trig, bus_addr, cfg_line_freq}, {8'h2, 3'h6, 5'h05, 1'h0});
		cmd(`CMD_UNL);
		cmd(7'h27);
		chk(listener, 0);
		cmd(`CMD_DCL);
		chk({n_clear, bus_addr}, {8'h3, 5'h05});
		$display("clear done");
		status_bits = 7'h55;
		srq_pending = 1'b1;
		cmd(`CMD_SPE);
		cmd(7'h45);
		chk({poll_enabled, talker}, 2'b11);
		u_bus_ctrl_model.lines(0, 0, 0);
		chk({dio_n_oe, ~dio_n_in[6:0]}, {8'hFF, 7'h15});
		u_bus_ctrl_model.send(7'h00, 1'b0);
		chk(dio_n_oe, 0);
		cmd(7'h47);
		u_bus_ctrl_model.lines(0, 0, 0);
		chk({talker, dio_n_oe}, 0);
		cmd(`CMD_SPD);
		chk(poll_enabled, 0);
		cmd(7'h25);
		u_bus_ctrl_model.lines(0, 1, 1);
		chk({talker, listener}, 0);
		u_bus_ctrl_model.lines(0, 0, 1);
		$display("poll done");
		rst = 1'b1;
		u_bus_ctrl_model.wait_clk(2);
		rst = 1'b0;
		u_bus_ctrl_model.wait_clk(2);
		chk(bus_addr, `DEF_BUS_ADDR);
		$display("reset done");
		give_verdict();
	end
endmodule : tb
